// *** hdl/cga_map.vh ***
// constants for the channel gating and adc trigger block
`ifndef CGA_MAP_VH
`define CGA_MAP_VH
`define CGA_GATE_UNIT_COUNT 8
`define CGA_TIMING_GENERATOR_COUNT 9
`define CGA_TRIGGER_SOURCE_COUNT 16
`define CGA_DELAY_WIDTH 16
`define CGA_CLK_MHZ 200
`define CGA_BOARD_CLK_MHZ 150
`define CGA_EXT_LATENCY 6
`define CGA_ADC_MIN_SPACING 45
`define CGA_TS_PS 833
`define CGA_TS_WIDTH 48
`define CGA_ADC_WIDTH 16
// trigger source bit positions
`define CGA_SRC_AUTO 11
`define CGA_SRC_CNV1 12
`define CGA_SRC_CNV2 13
`define CGA_SRC_SOFT 14
`define CGA_SRC_ONE 15
`endif

// *** hdl/cga_gating.v ***
// gating units, adc timing generator and adc sample packet insertion
`timescale 1ns/1ps
`include "cga_map.vh"
//=========================================================
// Function
// - extra timing generator drives the adc trigger connector.
// - each tdc channel has its own gate unit of generator form.
// - nine timing generators: eight gates plus the adc one.
// - trigger selection covers sixteen sources.
// - hits recorded only while the channel gate is open.
// - negate inverts gate open against generator activity.
// - retrigger while active restarts timer, extending activity.
// - retrigger before activation restarts full start delay.
// - without retrigger, later triggers ignored until stop reached.
// - external triggers delayed eight cycles (two sync stages, six-stage line); auto trigger undelayed.
// - gate filtering happens before the first level buffer.
// - gate holds last level, refreshes on reactivation.
// - rising adc trigger edge samples adc, inserts stamped packet.
// - packet timestamp resolution is 833 ps.
// - two interleaved converters, distinct sources and packet tag.
// - delays counted in board clock cycles.
// - selected sources combined by bitwise or.
// - software trigger source lasts exactly one cycle.
//=========================================================
module cga_gating #(
    parameter NG = `CGA_GATE_UNIT_COUNT,
    parameter NS = `CGA_TRIGGER_SOURCE_COUNT,
    parameter DW = `CGA_DELAY_WIDTH,
    parameter LAT = `CGA_EXT_LATENCY
) (
    input wire clk,
    input wire rst,
    input wire [NG-1:0] tdc_in,
    input wire [2:0] sync_in,
    input wire auto_trigger_source,
    input wire sw_trigger_req,
    input wire [NS*(NG+1)-1:0] src_mask,
    input wire [DW*(NG+1)-1:0] start_delay,
    input wire [DW*(NG+1)-1:0] stop_delay,
    input wire [NG:0] negate,
    input wire [NG:0] retrigger,
    input wire [NG-1:0] hit_valid,
    input wire [`CGA_ADC_WIDTH-1:0] adc_value,
    output reg [NG-1:0] first_level_buffer_valid,
    output reg [NG-1:0] gated_level,
    output reg [NG:0] gen_active,
    output reg adc_trigger_connector,
    output reg hit_packet_valid,
    output reg hit_packet_conv,
    output reg [`CGA_TS_WIDTH-1:0] hit_packet_ts,
    output reg [`CGA_ADC_WIDTH-1:0] hit_packet_adc
);
localparam NT = NG + 1;
// board clock ticks at 150/200 of clk: accumulate 150 per cycle
localparam [7:0] BINC = `CGA_BOARD_CLK_MHZ;
localparam [7:0] BMOD = `CGA_CLK_MHZ;
// clk period in ps; the stamp counts TS_RES ps units, six or seven a clock
localparam [15:0] TS_STEP = 16'h1388;
localparam [15:0] TS_RES = `CGA_TS_PS;
localparam [16:0] TS_SIX = 17'h0_0006 * TS_RES;
localparam [16:0] TS_SEVEN = 17'h0_0007 * TS_RES;
localparam [`CGA_TS_WIDTH-1:0] TS_ADD6 = {{(`CGA_TS_WIDTH-3){1'b0}}, 3'h6};
localparam [`CGA_TS_WIDTH-1:0] TS_ADD7 = {{(`CGA_TS_WIDTH-3){1'b0}}, 3'h7};

//=========================================================
// input synchronisers and board clock enable
reg [NG-1:0] tdc_s1_reg, tdc_s2_reg, tdc_d_reg;
reg [2:0] sync_s1_reg, sync_s2_reg;
reg sw_d_reg, sw_pulse_reg;
reg [7:0] bacc_reg;
reg btick_reg;
// nine bits: remainder plus increment can pass 255
wire [8:0] bacc_sum = {1'b0, bacc_reg} + {1'b0, BINC};
wire [8:0] bacc_wrap = bacc_sum - {1'b0, BMOD};
always @(posedge clk or posedge rst) begin
    if (rst) begin
        tdc_s1_reg <= 0;
        tdc_s2_reg <= 0;
        tdc_d_reg <= 0;
        sync_s1_reg <= 3'h0;
        sync_s2_reg <= 3'h0;
        sw_d_reg <= 1'b0;
        sw_pulse_reg <= 1'b0;
        bacc_reg <= 8'h00;
        btick_reg <= 1'b0;
    end else begin
        tdc_s1_reg <= tdc_in;
        tdc_s2_reg <= tdc_s1_reg;
        tdc_d_reg <= tdc_s2_reg;
        sync_s1_reg <= sync_in;
        sync_s2_reg <= sync_s1_reg;
        sw_d_reg <= sw_trigger_req;
        sw_pulse_reg <= sw_trigger_req & ~sw_d_reg;
        if (bacc_sum >= {1'b0, BMOD}) begin
            bacc_reg <= bacc_wrap[7:0];
            btick_reg <= 1'b1;
        end else begin
            bacc_reg <= bacc_sum[7:0];
            btick_reg <= 1'b0;
        end
    end
end

//=========================================================
// external trigger latency line
wire [NG-1:0] tdc_rise = tdc_s2_reg & ~tdc_d_reg;
reg [NG+2:0] ext_dly_reg [0:LAT-1];
integer k;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        for (k = 0; k < LAT; k = k + 1)
            ext_dly_reg[k] <= 0;
    end else begin
        ext_dly_reg[0] <= {sync_s2_reg, tdc_rise};
        for (k = 1; k < LAT; k = k + 1)
            ext_dly_reg[k] <= ext_dly_reg[k-1];
    end
end
reg [1:0] cnv_reg;
wire [NS-1:0] src_vec;
assign src_vec[NG+2:0] = ext_dly_reg[LAT-1];
assign src_vec[`CGA_SRC_AUTO] = auto_trigger_source;
assign src_vec[`CGA_SRC_CNV1] = cnv_reg[0];
assign src_vec[`CGA_SRC_CNV2] = cnv_reg[1];
assign src_vec[`CGA_SRC_SOFT] = sw_pulse_reg;
assign src_vec[`CGA_SRC_ONE] = 1'b1;

//=========================================================
// timing generators: gates 0..NG-1, adc generator at NG
// nine generators
genvar g;
generate
    for (g = 0; g < NT; g = g + 1) begin : gen_tg
        wire [DW-1:0] st = start_delay[g*DW +: DW];
        wire [DW-1:0] sp = stop_delay[g*DW +: DW];
        wire trig = |(src_vec & src_mask[g*NS +: NS]);
        reg run_reg;
        reg [DW-1:0] cnt_reg;
        wire [DW-1:0] cnt_next = cnt_reg + 1'b1;
        always @(posedge clk or posedge rst) begin
            if (rst) begin
                run_reg <= 1'b0;
                cnt_reg <= 0;
                gen_active[g] <= 1'b0;
            end else if (trig && (!run_reg || retrigger[g])) begin
                run_reg <= 1'b1;
                cnt_reg <= 0;
                // an active gate stays active; a waiting one restarts
                gen_active[g] <= gen_active[g] | (st == 0);
            end else if (run_reg && btick_reg) begin
                cnt_reg <= cnt_next;
                if (cnt_next >= sp) begin
                    run_reg <= 1'b0;
                    gen_active[g] <= 1'b0;
                end else if (cnt_next >= st) begin
                    gen_active[g] <= 1'b1;
                end
            end
        end
        if (g < NG) begin : gate
            wire open = gen_active[g] ^ negate[g];
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    first_level_buffer_valid[g] <= 1'b0;
                    gated_level[g] <= 1'b0;
                end else begin
                    first_level_buffer_valid[g] <= hit_valid[g] & open;
                    if (open)
                        gated_level[g] <= tdc_s2_reg[g];
                end
            end
        end
    end
endgenerate

//=========================================================
// adc trigger, interleaved converters and packets
reg adc_d_reg, conv_sel_reg;
reg [`CGA_TS_WIDTH-1:0] ts_reg;
reg [15:0] ts_frac_reg;
wire [16:0] frac_sum = {1'b0, ts_frac_reg} + {1'b0, TS_STEP};
wire [16:0] frac_six = frac_sum - TS_SIX;
wire [16:0] frac_seven = frac_sum - TS_SEVEN;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        adc_trigger_connector <= 1'b0;
        adc_d_reg <= 1'b0;
        conv_sel_reg <= 1'b0;
        cnv_reg <= 2'h0;
        ts_reg <= 0;
        ts_frac_reg <= 16'h0000;
        hit_packet_valid <= 1'b0;
        hit_packet_conv <= 1'b0;
        hit_packet_ts <= 0;
        hit_packet_adc <= 0;
    end else begin
        adc_trigger_connector <= gen_active[NG] ^ negate[NG];
        adc_d_reg <= adc_trigger_connector;
        // 833 ps timestamp ticks
        // remainder stays below one unit, so the stamp never drifts
        if (frac_sum >= TS_SEVEN) begin
            ts_reg <= ts_reg + TS_ADD7;
            ts_frac_reg <= frac_seven[15:0];
        end else begin
            ts_reg <= ts_reg + TS_ADD6;
            ts_frac_reg <= frac_six[15:0];
        end
        cnv_reg <= 2'h0;
        hit_packet_valid <= 1'b0;
        // rising edge samples and emits packet
        if (adc_trigger_connector && !adc_d_reg) begin
            conv_sel_reg <= ~conv_sel_reg;
            cnv_reg <= conv_sel_reg ? 2'h2 : 2'h1;
            hit_packet_valid <= 1'b1;
            hit_packet_conv <= conv_sel_reg;
            hit_packet_ts <= ts_reg;
            hit_packet_adc <= adc_value;
        end
    end
end
endmodule // cga_gating

// *** test/cga_gating_assertions.sv ***
// port-level checks of the gating and adc trigger block
`timescale 1ns/1ps
`include "cga_map.vh"
module cga_gating_chk (
    input wire clk,
    input wire rst,
    input wire [7:0] hit_valid,
    input wire [8:0] negate,
    input wire [8:0] gen_active,
    input wire [7:0] first_level_buffer_valid,
    input wire [7:0] gated_level,
    input wire adc_trigger_connector,
    input wire hit_packet_valid,
    input wire hit_packet_conv,
    input wire [`CGA_TS_WIDTH-1:0] hit_packet_ts
);
    logic seen_reg, conv_reg;
    logic [`CGA_TS_WIDTH-1:0] ts_reg;
    wire open0 = gen_active[0] ^ negate[0];
    // =========================================================
    // last packet seen
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_reg <= 1'b0;
            conv_reg <= 1'b0;
            ts_reg <= '0;
        end else if (hit_packet_valid) begin
            seen_reg <= 1'b1;
            conv_reg <= hit_packet_conv;
            ts_reg <= hit_packet_ts;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_rise;
        $rose(adc_trigger_connector);
    endsequence
    // =========================================================
    // assertions
    AST_FLB_CAUSE: assert property (first_level_buffer_valid[0] |->
        $past(hit_valid[0])) else $error("buffer strobe without hit");
    AST_FLB_OPEN: assert property (first_level_buffer_valid[0] |->
        $past(open0) || open0) else $error("hit passed a closed gate");
    AST_LEVEL_HOLD: assert property ($changed(gated_level[0]) |->
        open0 || $past(open0) || $past(open0, 2))
        else $error("held level moved while gate closed");
    AST_CONN: assert property ($rose(gen_active[8]) && !negate[8] |=>
        adc_trigger_connector) else $error("connector missed generator");
    AST_PKT_AFTER: assert property (s_rise |=> hit_packet_valid)
        else $error("no packet after trigger edge");
    AST_PKT_CAUSE: assert property (hit_packet_valid |->
        $past(adc_trigger_connector) && !$past(adc_trigger_connector, 2))
        else $error("packet without trigger edge");
    AST_PKT_PULSE: assert property (hit_packet_valid |=>
        !hit_packet_valid) else $error("packet strobe too long");
    AST_CONV_ALT: assert property (hit_packet_valid && seen_reg |->
        hit_packet_conv != conv_reg) else $error("converters not alternating");
    AST_TS_GROW: assert property (hit_packet_valid && seen_reg |->
        hit_packet_ts > ts_reg) else $error("timestamp did not advance");
endmodule // cga_gating_chk

// *** test/cga_far_side.sv ***
// far-side model: channel levels, sync clocks, auto trigger
`timescale 1ns/1ps
module cga_far_side (
    input wire logic clk,
    output logic [7:0] tdc_in = 8'h00,
    output logic [2:0] sync_in = 3'h0,
    output logic auto_trigger_source = 1'b0
);
    // one short pulse, caller keeps spacing
    task automatic pulse(input int i);
        @(negedge clk);
        if (i < 8) tdc_in[i] = 1'b1;
        else if (i < 11) sync_in[i-8] = 1'b1;
        else auto_trigger_source = 1'b1;
        @(negedge clk);
        tdc_in = 8'h00;
        sync_in = 3'h0;
        auto_trigger_source = 1'b0;
    endtask
    // channel levels that stay put
    task automatic hold(input logic [7:0] v);
        @(negedge clk);
        tdc_in = v;
    endtask
endmodule // cga_far_side

// *** test/testbench.sv ***
// self-checking bench for the gating and adc trigger block
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, sw_trigger_req = 0, c;
    logic [7:0] hit_valid = 0;
    logic [143:0] src_mask = 0, start_delay = 0, stop_delay = 0;
    logic [8:0] negate = 0, retrigger = 0;
    logic [15:0] adc_value = 0;
    wire [7:0] tdc_in, fbv, lvl;
    wire [2:0] sync_in;
    wire [8:0] gen_active;
    wire auto_src, conn, pv, pc;
    wire [47:0] pts;
    logic [47:0] ts0 = 0;
    wire [15:0] padc;
    int bad_count = 0, num_checks = 0, t0, t1, w;
    always #2.5 clk = ~clk;
    cga_far_side far (.clk(clk), .tdc_in(tdc_in), .sync_in(sync_in),
        .auto_trigger_source(auto_src));
    cga_gating uut (.clk(clk), .rst(rst), .tdc_in(tdc_in), .sync_in(sync_in),
        .auto_trigger_source(auto_src), .sw_trigger_req(sw_trigger_req),
        .src_mask(src_mask), .start_delay(start_delay), .negate(negate),
        .stop_delay(stop_delay), .retrigger(retrigger), .hit_valid(hit_valid),
        .adc_value(adc_value), .first_level_buffer_valid(fbv),
        .gated_level(lvl), .gen_active(gen_active), .hit_packet_conv(pc),
        .adc_trigger_connector(conn), .hit_packet_valid(pv),
        .hit_packet_ts(pts), .hit_packet_adc(padc));
    task automatic chk(input string n, input logic [47:0] s, e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cfg(input int g, input [15:0] m, s, p, input n, r);
        @(negedge clk);
        src_mask[g*16+:16] = m;
        start_delay[g*16+:16] = s;
        stop_delay[g*16+:16] = p;
        negate[g] = n;
        retrigger[g] = r;
    endtask
    // cycles to activation, then cycles active
    task automatic run(input int s, input bit again, output int t, n);
        t = 0;
        n = 0;
        far.pulse(s);
        while (gen_active[0] !== 1'b1 && t < 99) begin
            @(negedge clk);
            t++;
        end
        if (again) far.pulse(s);
        if (again) n = 2;
        while (gen_active[0] === 1'b1 && n < 99) begin
            @(negedge clk);
            n++;
        end
        repeat (20) @(negedge clk);
    endtask
    initial begin
        #20000;
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 0;
        cfg(0, 16'h0801, 16'h0004, 16'h0008, 0, 0);
        run(11, 1, t0, w);
        chk("rise", t0 >= 5 && t0 <= 9, 1);
        chk("width", w >= 5 && w <= 6, 1);
        cfg(0, 16'h0800, 16'h0004, 16'h0008, 0, 1);
        run(11, 1, t0, w);
        chk("retrig", w >= 8, 1);
        for (int s = 0; s < 9; s += 8) begin
            cfg(0, 16'h0001 << s, 16'h0004, 16'h0008, 0, 0);
            run(s, 0, t1, w);
            chk("ext_lat", t1 - t0 >= 7 && t1 - t0 <= 11, 1);
        end
        for (int n = 0; n < 2; n++) begin
            cfg(0, 16'h0000, 16'h0004, 16'h0008, n[0], 0);
            hit_valid[0] = 1;
            @(negedge clk);
            hit_valid[0] = 0;
            chk("flb", fbv[0], n[0]);
        end
        cfg(0, 16'h0000, 16'h0004, 16'h0008, 1, 0);
        far.hold(8'h01);
        repeat (4) @(negedge clk);
        chk("lvl_open", lvl[0], 1);
        cfg(0, 16'h0000, 16'h0004, 16'h0008, 0, 0);
        far.hold(8'h00);
        repeat (4) @(negedge clk);
        chk("lvl_hold", lvl[0], 1);
        cfg(0, 16'h0000, 16'h0004, 16'h0008, 1, 0);
        repeat (4) @(negedge clk);
        chk("lvl_new", lvl[0], 0);
        // stop of 45, triggers 84 cycles apart
        cfg(8, 16'h4000, 16'h0000, 16'h002d, 0, 0);
        // gate 1 listens to both converters
        cfg(1, 16'h3000, 16'h0000, 16'h0004, 0, 0);
        for (int k = 0; k < 2; k++) begin
            adc_value = 16'h1230 + k;
            sw_trigger_req = 1;
            t0 = 0;
            while (pv !== 1'b1 && t0 < 99) begin
                @(negedge clk);
                t0++;
            end
            chk("adc", padc, adc_value);
            if (k == 1) chk("conv", pc, !c);
            // 84 clocks of 5 ns in 833 ps units
            if (k == 1)
                chk("ts_step", pts - ts0 inside {[504:505]}, 1);
            c = pc;
            ts0 = pts;
            sw_trigger_req = 0;
            @(negedge clk);
            chk("cnv_src", gen_active[1], 1);
            repeat (79) @(negedge clk);
        end
        stop_test;
    end
endmodule // testbench
bind cga_gating cga_gating_chk chk_i (.clk(clk), .rst(rst),
    .hit_valid(hit_valid), .negate(negate), .gen_active(gen_active),
    .first_level_buffer_valid(first_level_buffer_valid),
    .gated_level(gated_level), .adc_trigger_connector(adc_trigger_connector),
    .hit_packet_valid(hit_packet_valid), .hit_packet_conv(hit_packet_conv),
    .hit_packet_ts(hit_packet_ts));
